// [timer16_params.svh]
// Purpose: address map, field positions and reset values of the 16-bit timer block
// Assumes: byte-wide memory-mapped access from the local processor
// Notes:   definitions only
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// register addresses
`define ADDR_PORT_DIR        16'hFF22
`define ADDR_ANALOG_SEL      16'hFF84
`define ADDR_PRESCALE        16'hFF61
`define ADDR_TIMER_MODE      16'hFF60
`define ADDR_CAPCOMP_CTRL    16'hFF62
`define ADDR_PORT_LATCH      16'hFF02
`define ADDR_COUNT_LO        16'hFF10
`define ADDR_COUNT_HI        16'hFF11
`define ADDR_CMP_A_LO        16'hFF12
`define ADDR_CMP_A_HI        16'hFF13
`define ADDR_CMP_B_LO        16'hFF14
`define ADDR_CMP_B_HI        16'hFF15

// reset values
`define RST_PORT_DIR         4'hF
`define RST_ANALOG_SEL       4'h0
`define RST_BYTE             8'h00
`define RST_WORD             16'h0000

// fixed upper nibbles of the port registers
`define DIR_FIXED_HI         4'hF
`define ANALOG_FIXED_HI      4'h0

// field positions
`define PRS_CLK_LSB          0
`define PRS_EDGE_A_LSB       4
`define PRS_EDGE_B_LSB       6
`define TMODE_OVF_BIT        0
`define TMODE_MODE_LSB       2
`define TMODE_TOGGLE_BIT     4
`define CCR_A_CAPTURE_BIT    0
`define CCR_B_CAPTURE_BIT    2

// counter constants
`define COUNT_MAX            16'hFFFF
`define COUNT_ZERO           16'h0000
`define COUNT_ONE            16'h0001
`define DIV4_LAST            8'h03
`define DIV256_LAST          8'hFF
`define DIV4_MASK            8'h03
`define PRESC_ONE            8'h01

`endif

// [timer16_pkg.sv]
// Purpose: shared types of the 16-bit timer block
// Assumes: nothing beyond the params header
// Notes:   codes are written out so register fields map straight onto them
package timer16_pkg;

   typedef enum logic [1:0]
   {
      MODE_STOP      = 2'b00,
      MODE_FREE_RUN  = 2'b01,
      MODE_RESTART   = 2'b10,
      MODE_CLR_MATCH = 2'b11
   } timer_mode_type;

   typedef enum logic [1:0]
   {
      CLK_FXP        = 2'b00,
      CLK_FXP_DIV4   = 2'b01,
      CLK_FXP_DIV256 = 2'b10,
      CLK_EDGE_A     = 2'b11
   } clk_sel_type;

   typedef enum logic [1:0]
   {
      EDGE_FALL      = 2'b00,
      EDGE_RISE      = 2'b01,
      EDGE_BAD       = 2'b10,
      EDGE_BOTH      = 2'b11
   } edge_sel_type;

endpackage : timer16_pkg

// [edge_filter.sv]
// Purpose: two-sample noise filter and valid-edge detector for one timer input
// Assumes: pin is synchronous to clk
// Notes:   a new level is accepted only when seen on two consecutive samples
`timescale 1ns/100ps

module edge_filter
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // control
   input  wire logic                    enable,
   input  wire logic                    sample_en,
   input  wire timer16_pkg::edge_sel_type edge_sel,
   // pin and result
   input  wire logic                    pin,
   output logic                         edge_pulse
);
   import timer16_pkg::*;

   logic  sample_r;
   logic  sample_nxt;
   logic  level_r;
   logic  level_nxt;
   logic  pulse_r;
   logic  pulse_nxt;

   always_comb
   begin
      sample_nxt = sample_r;
      level_nxt  = level_r;
      pulse_nxt  = 1'b0;
      // stopped: both levels held low, so a high pin gives a rising edge on start
      if (!enable)
      begin
         sample_nxt = 1'b0;
         level_nxt  = 1'b0;
      end
      else if (sample_en)
      begin
         sample_nxt = pin;
         if ((pin == sample_r) && (pin != level_r))
         begin
            level_nxt = pin;
            unique case (edge_sel)
               EDGE_FALL: pulse_nxt = ~pin;
               EDGE_RISE: pulse_nxt = pin;
               EDGE_BOTH: pulse_nxt = 1'b1;
               EDGE_BAD:  pulse_nxt = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sample_r <= 1'b0;
         level_r  <= 1'b0;
         pulse_r  <= 1'b0;
      end
      else
      begin
         sample_r <= sample_nxt;
         level_r  <= level_nxt;
         pulse_r  <= pulse_nxt;
      end
   end

   assign edge_pulse = pulse_r;

endmodule : edge_filter

// [timer16_interval_event_capture.sv]
// Purpose: 16-bit interval timer, event counter and pulse-width capture with port-2 routing
// Assumes: byte accesses from the processor, pins synchronous to mclk (200 MHz = fxp)
// Notes:   16-bit registers are reached as low/high byte pairs
`timescale 1ns/100ps

`include "timer16_params.svh"

module timer16_interval_event_capture
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // processor byte access
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   output logic      [7:0]  cpu_rdata,
   // port 2 pins, bit 0 capture_in_a, bit 1 capture_in_b / timer_out_pin
   input  wire logic [3:0]  port_pin_in,
   output logic      [3:0]  port_pin_out,
   output logic      [3:0]  port_pin_oe_n,
   // interrupt requests
   output logic             match_irq_a,
   output logic             capture_irq_b
);
   import timer16_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // reset release
   logic        rst_meta_r;
   logic        rst_sync_n;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state
   logic [3:0]     port_dir_r,   port_dir_nxt;
   logic [3:0]     analog_sel_r, analog_sel_nxt;
   logic [3:0]     port_latch_r, port_latch_nxt;
   logic [7:0]     prescale_r,   prescale_nxt;
   timer_mode_type mode_r,       mode_nxt;
   logic           toggle_en_r,  toggle_en_nxt;
   logic           ovf_r,        ovf_nxt;
   logic           a_capture_r,  a_capture_nxt;
   logic           b_capture_r,  b_capture_nxt;
   logic [15:0]    count_r,      count_nxt;
   logic [15:0]    cmp_a_r,      cmp_a_nxt;
   logic [15:0]    cmp_b_r,      cmp_b_nxt;
   logic [7:0]     presc_cnt_r,  presc_cnt_nxt;
   logic           tout_r,       tout_nxt;
   logic           irq_a_r,      irq_a_nxt;
   logic           irq_b_r,      irq_b_nxt;
   logic [7:0]     rdata_r,      rdata_nxt;

   // decoded controls and events
   logic           running;
   clk_sel_type    clk_sel;
   edge_sel_type   edge_sel_a;
   edge_sel_type   edge_sel_b;
   logic           pin_a;
   logic           pin_b;
   logic           count_tick;
   logic           edge_a_fxp;
   logic           edge_a_cap;
   logic           edge_b_cap;
   logic           match_a;
   logic           cap_into_a;
   logic           cap_into_b;
   logic           wrap;
   logic [15:0]    count_inc;

   assign running    = (mode_r != MODE_STOP);
   assign clk_sel    = clk_sel_type'(prescale_r[`PRS_CLK_LSB +: 2]);
   assign edge_sel_a = edge_sel_type'(prescale_r[`PRS_EDGE_A_LSB +: 2]);
   assign edge_sel_b = edge_sel_type'(prescale_r[`PRS_EDGE_B_LSB +: 2]);
   // a pin in converter mode gives the timer a steady low
   assign pin_a      = port_pin_in[0] & ~analog_sel_r[0];
   assign pin_b      = port_pin_in[1] & ~analog_sel_r[1];

   ////////////////////////////////////////////////////////////////////////////////////////////
   // count clock selection
   always_comb
   begin
      unique case (clk_sel)
         CLK_FXP:        count_tick = running;
         CLK_FXP_DIV4:   count_tick = running & ((presc_cnt_r & `DIV4_MASK) == `DIV4_LAST);
         CLK_FXP_DIV256: count_tick = running & (presc_cnt_r == `DIV256_LAST);
         CLK_EDGE_A:     count_tick = edge_a_fxp;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // input filters: the event-count path samples at fxp, capture paths at the count clock
   edge_filter u_filt_a_fxp
   (
      .clk        (mclk),
      .rst_n      (rst_sync_n),
      .enable     (running),
      .sample_en  (1'b1),
      .edge_sel   (edge_sel_a),
      .pin        (pin_a),
      .edge_pulse (edge_a_fxp)
   );

   edge_filter u_filt_a_cap
   (
      .clk        (mclk),
      .rst_n      (rst_sync_n),
      .enable     (running),
      .sample_en  (count_tick),
      .edge_sel   (edge_sel_a),
      .pin        (pin_a),
      .edge_pulse (edge_a_cap)
   );

   edge_filter u_filt_b_cap
   (
      .clk        (mclk),
      .rst_n      (rst_sync_n),
      .enable     (running),
      .sample_en  (count_tick),
      .edge_sel   (edge_sel_b),
      .pin        (pin_b),
      .edge_pulse (edge_b_cap)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // counter events
   assign count_inc  = count_r + `COUNT_ONE;
   assign match_a    = count_tick & ~a_capture_r & (count_r == cmp_a_r);
   // with the input a edge as count clock it cannot also be a capture trigger
   assign cap_into_b = edge_a_cap & b_capture_r & (clk_sel != CLK_EDGE_A);
   assign cap_into_a = edge_b_cap & a_capture_r;
   assign wrap       = count_tick & (count_r == `COUNT_MAX) & ~match_a;

   always_comb
   begin
      count_nxt     = count_r;
      presc_cnt_nxt = running ? (presc_cnt_r + `PRESC_ONE) : `RST_BYTE;
      ovf_nxt       = ovf_r;
      tout_nxt      = tout_r;
      if (!running)
         count_nxt = `COUNT_ZERO;
      else if (mode_r == MODE_RESTART && cap_into_b)
         count_nxt = `COUNT_ZERO;
      else if (mode_r == MODE_CLR_MATCH && match_a)
         count_nxt = `COUNT_ZERO;
      else if (count_tick)
         count_nxt = count_inc;
      // software clear of the flag by writing 0; a same-cycle overflow still wins
      if (cpu_wr && cpu_addr == `ADDR_TIMER_MODE && !cpu_wdata[`TMODE_OVF_BIT])
         ovf_nxt = 1'b0;
      if (mode_r == MODE_CLR_MATCH)
      begin
         if (match_a && cmp_a_r == `COUNT_MAX)
            ovf_nxt = 1'b1;
      end
      else if (wrap)
         ovf_nxt = 1'b1;
      if (match_a && toggle_en_r)
         tout_nxt = ~tout_r;
      if (!running)
         tout_nxt = 1'b0;
      irq_a_nxt = match_a | cap_into_a;
      irq_b_nxt = cap_into_b;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // register writes and reads
   always_comb
   begin
      port_dir_nxt   = port_dir_r;
      analog_sel_nxt = analog_sel_r;
      port_latch_nxt = port_latch_r;
      prescale_nxt   = prescale_r;
      mode_nxt       = mode_r;
      toggle_en_nxt  = toggle_en_r;
      a_capture_nxt  = a_capture_r;
      b_capture_nxt  = b_capture_r;
      cmp_a_nxt      = cmp_a_r;
      cmp_b_nxt      = cmp_b_r;
      rdata_nxt      = rdata_r;
      if (cpu_wr)
      begin
         unique case (cpu_addr)
            `ADDR_PORT_DIR:     port_dir_nxt   = cpu_wdata[3:0];
            `ADDR_ANALOG_SEL:   analog_sel_nxt = cpu_wdata[3:0];
            `ADDR_PORT_LATCH:   port_latch_nxt = cpu_wdata[3:0];
            `ADDR_PRESCALE:     prescale_nxt   = {cpu_wdata[7:4], 2'b00, cpu_wdata[1:0]};
            `ADDR_TIMER_MODE:
            begin
               mode_nxt      = timer_mode_type'(cpu_wdata[`TMODE_MODE_LSB +: 2]);
               toggle_en_nxt = cpu_wdata[`TMODE_TOGGLE_BIT];
            end
            `ADDR_CAPCOMP_CTRL:
            begin
               a_capture_nxt = cpu_wdata[`CCR_A_CAPTURE_BIT];
               b_capture_nxt = cpu_wdata[`CCR_B_CAPTURE_BIT];
            end
            `ADDR_CMP_A_LO:     cmp_a_nxt[7:0]  = cpu_wdata;
            `ADDR_CMP_A_HI:     cmp_a_nxt[15:8] = cpu_wdata;
            `ADDR_CMP_B_LO:     cmp_b_nxt[7:0]  = cpu_wdata;
            `ADDR_CMP_B_HI:     cmp_b_nxt[15:8] = cpu_wdata;
            default:            cmp_a_nxt = cmp_a_r;
         endcase
      end
      // a capture lands after any same-cycle processor write
      if (cap_into_a)
         cmp_a_nxt = count_r;
      if (cap_into_b)
         cmp_b_nxt = count_r;
      if (cpu_rd)
      begin
         unique case (cpu_addr)
            `ADDR_PORT_DIR:     rdata_nxt = {`DIR_FIXED_HI, port_dir_r};
            `ADDR_ANALOG_SEL:   rdata_nxt = {`ANALOG_FIXED_HI, analog_sel_r};
            `ADDR_PORT_LATCH:   rdata_nxt = {4'h0, port_latch_r};
            `ADDR_PRESCALE:     rdata_nxt = prescale_r;
            `ADDR_TIMER_MODE:   rdata_nxt = {3'b000, toggle_en_r, mode_r, 1'b0, ovf_r};
            `ADDR_CAPCOMP_CTRL: rdata_nxt = {5'b00000, b_capture_r, 1'b0, a_capture_r};
            `ADDR_COUNT_LO:     rdata_nxt = count_r[7:0];
            `ADDR_COUNT_HI:     rdata_nxt = count_r[15:8];
            `ADDR_CMP_A_LO:     rdata_nxt = cmp_a_r[7:0];
            `ADDR_CMP_A_HI:     rdata_nxt = cmp_a_r[15:8];
            `ADDR_CMP_B_LO:     rdata_nxt = cmp_b_r[7:0];
            `ADDR_CMP_B_HI:     rdata_nxt = cmp_b_r[15:8];
            default:            rdata_nxt = `RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         port_dir_r   <= `RST_PORT_DIR;
         analog_sel_r <= `RST_ANALOG_SEL;
         port_latch_r <= 4'h0;
         prescale_r   <= `RST_BYTE;
         mode_r       <= MODE_STOP;
         toggle_en_r  <= 1'b0;
         ovf_r        <= 1'b0;
         a_capture_r  <= 1'b0;
         b_capture_r  <= 1'b0;
         count_r      <= `RST_WORD;
         cmp_a_r      <= `RST_WORD;
         cmp_b_r      <= `RST_WORD;
         presc_cnt_r  <= `RST_BYTE;
         tout_r       <= 1'b0;
         irq_a_r      <= 1'b0;
         irq_b_r      <= 1'b0;
         rdata_r      <= `RST_BYTE;
      end
      else
      begin
         port_dir_r   <= port_dir_nxt;
         analog_sel_r <= analog_sel_nxt;
         port_latch_r <= port_latch_nxt;
         prescale_r   <= prescale_nxt;
         mode_r       <= mode_nxt;
         toggle_en_r  <= toggle_en_nxt;
         ovf_r        <= ovf_nxt;
         a_capture_r  <= a_capture_nxt;
         b_capture_r  <= b_capture_nxt;
         count_r      <= count_nxt;
         cmp_a_r      <= cmp_a_nxt;
         cmp_b_r      <= cmp_b_nxt;
         presc_cnt_r  <= presc_cnt_nxt;
         tout_r       <= tout_nxt;
         irq_a_r      <= irq_a_nxt;
         irq_b_r      <= irq_b_nxt;
         rdata_r      <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // pins: timer output is OR-ed with the latch, so the latch must be 0 to see it
   always_comb
   begin
      port_pin_out    = port_latch_r;
      port_pin_out[1] = port_latch_r[1] | tout_r;
      port_pin_oe_n   = port_dir_r | analog_sel_r;
   end

   assign cpu_rdata     = rdata_r;
   assign match_irq_a   = irq_a_r;
   assign capture_irq_b = irq_b_r;

endmodule : timer16_interval_event_capture

// [timer16_interval_event_capture_sva.sv]
// Purpose: port-level checks of the 16-bit timer block
// Assumes: one clock domain, byte register strobes
// Notes:   interval spacing is checked only in clear-on-match mode at fxp or fxp/4
`timescale 1ns/100ps
`include "timer16_params.svh"
module timer16_sva
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // register access
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0]  cpu_wdata,
   input wire logic        cpu_wr,
   input wire logic        cpu_rd,
   input wire logic [7:0]  cpu_rdata,
   // pins and requests
   input wire logic [3:0]  port_pin_in,
   input wire logic [3:0]  port_pin_out,
   input wire logic [3:0]  port_pin_oe_n,
   input wire logic        match_irq_a,
   input wire logic        capture_irq_b
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic [15:0] cmp_r, cmp_nxt;
   logic [1:0]  sel_r, sel_nxt;
   logic [19:0] gap_r, gap_nxt, want;
   logic        arm_r, arm_nxt;
   logic        clr_r, clr_nxt;
   ////////////////////////////////////////////////////////////////////////////////
   // shadow of compare a and clock select; any write disarms the spacing check
   always_comb
   begin
      cmp_nxt = cmp_r;
      sel_nxt = sel_r;
      if (cpu_wr && cpu_addr == `ADDR_CMP_A_LO) cmp_nxt[7:0] = cpu_wdata;
      if (cpu_wr && cpu_addr == `ADDR_CMP_A_HI) cmp_nxt[15:8] = cpu_wdata;
      if (cpu_wr && cpu_addr == `ADDR_PRESCALE) sel_nxt = cpu_wdata[1:0];
      // other modes never clear on match, so their request spacing is not an interval
      clr_nxt = clr_r;
      if (cpu_wr && cpu_addr == `ADDR_TIMER_MODE) clr_nxt = &cpu_wdata[`TMODE_MODE_LSB +: 2];
      gap_nxt = match_irq_a ? 20'h0_0000 : (&gap_r ? gap_r : gap_r + 20'h0_0001);
      arm_nxt = cpu_wr ? 1'b0 : (match_irq_a | arm_r);
      want = (({4'h0, cmp_r} + 20'h0_0001) << (sel_r[0] ? 2 : 0)) - 20'h0_0001;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp_r <= 16'h0000;
         sel_r <= 2'h0;
         gap_r <= 20'h0_0000;
         arm_r <= 1'b0;
         clr_r <= 1'b0;
      end
      else
      begin
         cmp_r <= cmp_nxt;
         sel_r <= sel_nxt;
         gap_r <= gap_nxt;
         arm_r <= arm_nxt;
         clr_r <= clr_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_irq_a_pulse;
      match_irq_a |=> !match_irq_a;
   endproperty
   a_irq_a_pulse: assert property (p_irq_a_pulse)
      else $error("match request longer than one cycle");
   property p_irq_b_pulse;
      $rose(capture_irq_b) |=> $fell(capture_irq_b);
   endproperty
   a_irq_b_pulse: assert property (p_irq_b_pulse)
      else $error("capture request longer than one cycle");
   property p_dir_hi;
      cpu_rd && cpu_addr == `ADDR_PORT_DIR |=> cpu_rdata[7:4] == `DIR_FIXED_HI;
   endproperty
   a_dir_hi: assert property (p_dir_hi)
      else $error("direction upper bits not ones");
   property p_ana_hi;
      cpu_rd && cpu_addr == `ADDR_ANALOG_SEL |-> ##1 cpu_rdata[7:4] == `ANALOG_FIXED_HI;
   endproperty
   a_ana_hi: assert property (p_ana_hi)
      else $error("analog upper bits not zeros");
   property p_rst_oe;
      $rose(rst_n) |-> port_pin_oe_n == 4'hF && !match_irq_a && !capture_irq_b;
   endproperty
   a_rst_oe: assert property (p_rst_oe)
      else $error("pins driven after reset");
   property p_dir_oe;
      cpu_wr && cpu_addr == `ADDR_PORT_DIR && cpu_wdata[3:0] == 4'hF
         |-> ##[1:3] port_pin_oe_n == 4'hF;
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("input direction leaves buffer on");
   property p_ana_oe;
      cpu_wr && cpu_addr == `ADDR_ANALOG_SEL && cpu_wdata[3:0] == 4'hF
         |-> ##[1:3] port_pin_oe_n == 4'hF;
   endproperty
   a_ana_oe: assert property (p_ana_oe)
      else $error("converter mode leaves buffer on");
   property p_gap;
      match_irq_a && arm_r && clr_r && !sel_r[1] |-> gap_r == want;
   endproperty
   a_gap: assert property (p_gap)
      else $error("match spacing wrong");
endmodule : timer16_sva
bind timer16_interval_event_capture timer16_sva timer16_sva_inst
(
   .mclk(mclk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
   .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .port_pin_in(port_pin_in),
   .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
   .match_irq_a(match_irq_a), .capture_irq_b(capture_irq_b)
);

// [pin_source.sv]
// Purpose: external pulse source on the timer input pins
// Assumes: called at a falling edge of mclk
// Notes:   unused pins toggle each cycle so a stale level is never trusted
`timescale 1ns/100ps
module pin_source
(
   // clock
   input  wire logic       mclk,
   // pins
   output logic      [3:0] src
);
   logic [1:0] lvl_r = 2'h0;
   logic       tog_r = 1'b0;
   always @(negedge mclk) tog_r <= !tog_r;
   assign src = {tog_r, !tog_r, lvl_r};
   // levels held several cycles so the two-sample filter always accepts them
   task pulses(input int pin, input int hi, input int lo, input int n);
      for (int i = 0; i < n; i++)
      begin
         lvl_r[pin] = 1'b1;
         repeat (hi) @(negedge mclk);
         lvl_r[pin] = 1'b0;
         repeat (lo) @(negedge mclk);
      end
   endtask : pulses
endmodule : pin_source

// [test_timer16_interval_event_capture.sv]
// Purpose: self-checking bench for the 16-bit timer block
// Assumes: inputs change on the falling edge of mclk
// Notes:   overflow run waits one full wrap of the counter
`timescale 1ns/100ps
`include "timer16_params.svh"
module test_timer16_interval_event_capture;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0]  cpu_wdata = 8'h00;
   logic        cpu_wr = 1'b0;
   logic        cpu_rd = 1'b0;
   logic [7:0]  cpu_rdata, d;
   logic [3:0]  src, pin_in, pin_out, pin_oe_n;
   logic        match_irq_a, capture_irq_b;
   logic [15:0] v1, v2, ca;
   logic [7:0]  cnt_exp [4] = '{8'h04, 8'h04, 8'h00, 8'h02};
   int          miscompares = 0;
   int          n_tests = 0;
   int          n, per;
   always #2.5 mclk = !mclk;
   assign pin_in = (pin_oe_n & src) | (~pin_oe_n & pin_out);
   timer16_interval_event_capture timer16_interval_event_capture_inst
   (
      .mclk(mclk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .port_pin_in(pin_in),
      .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n),
      .match_irq_a(match_irq_a), .capture_irq_b(capture_irq_b)
   );
   pin_source pin_source_inst (.mclk(mclk), .src(src));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge mclk);
      cpu_addr = a;
      cpu_wdata = v;
      cpu_wr = 1'b1;
      @(negedge mclk);
      cpu_wr = 1'b0;
   endtask : wr
   task wr16(input logic [15:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 16'h0001, v[15:8]);
   endtask : wr16
   task rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge mclk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge mclk);
      cpu_rd = 1'b0;
      v = cpu_rdata;
   endtask : rd
   task rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
      rd(a, d);
      chk(what, 16'(exp), 16'(d));
   endtask : rchk
   task wait_irq(input bit b, input int lim);
      for (int k = 0; k < lim && (b ? capture_irq_b : match_irq_a) !== 1'b1; k++)
         @(negedge mclk);
      chk("request seen", 16'h0001, 16'(b ? capture_irq_b : match_irq_a));
   endtask : wait_irq
   task count_irq(input int cyc, output int cnt);
      cnt = 0;
      repeat (cyc)
      begin
         @(negedge mclk);
         if (match_irq_a === 1'b1) cnt++;
      end
   endtask : count_irq
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
      rchk("dir reset", `ADDR_PORT_DIR, 8'hFF);
      rchk("analog reset", `ADDR_ANALOG_SEL, 8'h00);
      rchk("unmapped", 16'hFFFE, 8'h00);
      wr(`ADDR_PORT_DIR, 8'h00);
      rchk("dir fixed", `ADDR_PORT_DIR, 8'hF0);
      wr(`ADDR_ANALOG_SEL, 8'hFF);
      rchk("analog fixed", `ADDR_ANALOG_SEL, 8'h0F);
      chk("oe analog", 16'h000F, 16'(pin_oe_n));
      wr(`ADDR_ANALOG_SEL, 8'h00);
      wr(`ADDR_PORT_LATCH, 8'h00);
      repeat (2) @(negedge mclk);
      chk("oe output", 16'h0000, 16'(pin_oe_n));
      chk("pin out", 16'h0000, 16'(pin_out));
      wr(`ADDR_PORT_DIR, 8'hFF);
      repeat (2) @(negedge mclk);
      chk("oe input", 16'h000F, 16'(pin_oe_n));
      // interval at fxp, fxp/4, fxp/256 with compare 1: period 2 count clocks
      for (int s = 0; s < 3; s++)
      begin
         wr(`ADDR_TIMER_MODE, 8'h00);
         wr(`ADDR_CAPCOMP_CTRL, 8'h00);
         wr16(`ADDR_CMP_A_LO, 16'h0001);
         wr(`ADDR_PRESCALE, 8'(s));
         wr(`ADDR_TIMER_MODE, 8'h0C);
         wait_irq(1'b0, 600);
         per = 2 * (s == 0 ? 1 : (s == 1 ? 4 : 256));
         count_irq(2 * per, n);
         chk("interval requests", 16'h0002, 16'(n));
      end
      // compare lowered below the count, then raised to the top value
      wr(`ADDR_TIMER_MODE, 8'h00);
      wr(`ADDR_PRESCALE, 8'h00);
      // timer output on pin one toggles on every match, period four at compare 1
      wr(`ADDR_PORT_DIR, 8'hFD);
      wr(`ADDR_TIMER_MODE, 8'h1C);
      wait_irq(1'b0, 10);
      d = {7'h00, pin_out[1]};
      repeat (2) @(negedge mclk);
      chk("timer out", 16'(!d[0]), 16'(pin_out[1]));
      wr(`ADDR_TIMER_MODE, 8'h00);
      wr(`ADDR_PORT_DIR, 8'hFF);
      wr16(`ADDR_CMP_A_LO, 16'h0020);
      wr(`ADDR_TIMER_MODE, 8'h0C);
      wait_irq(1'b0, 100);
      repeat (16) @(negedge mclk);
      wr16(`ADDR_CMP_A_LO, 16'h0004);
      count_irq(1000, n);
      chk("lowered compare", 16'h0000, 16'(n));
      rchk("overflow clear", `ADDR_TIMER_MODE, 8'h0C);
      wr16(`ADDR_CMP_A_LO, 16'hFFFF);
      wait_irq(1'b0, 70000);
      rchk("overflow set", `ADDR_TIMER_MODE, 8'h0D);
      // event counting for each edge code, four pulses, compare 5
      for (int e = 0; e < 4; e++)
      begin
         wr(`ADDR_TIMER_MODE, 8'h00);
         wr16(`ADDR_CMP_A_LO, 16'h0005);
         wr(`ADDR_PRESCALE, 8'(e << 4) | 8'h03);
         wr(`ADDR_TIMER_MODE, 8'h0C);
         fork
            pin_source_inst.pulses(0, 4, 4, 4);
            count_irq(40, n);
         join
         rchk("event count", `ADDR_COUNT_LO, cnt_exp[e]);
         chk("event requests", 16'(e == 3), 16'(n));
      end
      // pulse width on both edges: free run from input a, restart from input a,
      // free run from input b into register a
      for (int c = 0; c < 3; c++)
      begin
         ca = (c == 2) ? `ADDR_CMP_A_LO : `ADDR_CMP_B_LO;
         wr(`ADDR_TIMER_MODE, 8'h00);
         wr(`ADDR_CAPCOMP_CTRL, (c == 2) ? 8'h01 : 8'h04);
         wr(`ADDR_PRESCALE, (c == 2) ? 8'hC0 : 8'h30);
         wr(`ADDR_TIMER_MODE, (c == 1) ? 8'h08 : 8'h04);
         fork
            pin_source_inst.pulses(c == 2, 20, 20, 1);
            begin
               wait_irq(c != 2, 30);
               rd(ca, v1[7:0]);
               rd(ca + 16'h0001, v1[15:8]);
               wait_irq(c != 2, 30);
               rd(ca, v2[7:0]);
               rd(ca + 16'h0001, v2[15:8]);
            end
         join
         // restart: the counter reads 0 the tick after a capture, so width is capture plus one
         v1 = (c == 1) ? 16'hFFFF : v1;
         chk("pulse width", 16'h0014, v2 - v1);
      end
      stop_test();
   end
   initial
   begin
      #450000;
      miscompares++;
      stop_test();
   end
endmodule : test_timer16_interval_event_capture
